/* verilog/mcs_defines.svh */
`ifndef MCS_DEFINES_SVH
`define MCS_DEFINES_SVH

// Core clock and timing
`define MCS_CLK_MHZ       40
`define MCS_HOLD_S        2
`define MCS_HOLD_CYC      (`MCS_HOLD_S * `MCS_CLK_MHZ * 1000000)
`define MCS_NOFRAME_NS    100000
`define MCS_NOFRAME_CYC   12'(`MCS_NOFRAME_NS * `MCS_CLK_MHZ / 1000)
`define MCS_SYNC_TOL      12'h004

// Lower period bounds (core cycles) of each rate band
`define MCS_P_NONE        12'h6a4
`define MCS_P_32K         12'h42e
`define MCS_P_44K1        12'h366
`define MCS_P_48K         12'h2d9
`define MCS_P_64K         12'h21c
`define MCS_P_88K2        12'h1b3
`define MCS_P_96K         12'h16d
`define MCS_P_128K        12'h10e
`define MCS_P_176K4       12'h0d9
`define MCS_P_192K        12'h096

// Nominal word periods (core cycles)
`define MCS_N_32K         12'h4e2
`define MCS_N_44K1        12'h38b
`define MCS_N_48K         12'h341
`define MCS_N_64K         12'h271
`define MCS_N_88K2        12'h1c6
`define MCS_N_96K         12'h1a1
`define MCS_N_128K        12'h138
`define MCS_N_176K4       12'h0e3
`define MCS_N_192K        12'h0d0

// Channel counts and reset value
`define MCS_CH_56         7'h38
`define MCS_CH_64         7'h40
`define MCS_RST_CORE      '0
`endif

/* verilog/mcs_pkg.sv */
package mcs_pkg;
    typedef enum logic [3:0] {
        rate_none, rate_32k, rate_44k1, rate_48k, rate_64k,
        rate_88k2, rate_96k, rate_128k, rate_176k4, rate_192k
    } mcs_rate_type;

    typedef enum logic [1:0] {in_no_lock, in_lock, in_sync} mcs_in_status_type;
    typedef enum logic {class_compliant_mode, driver_normal_mode} mcs_op_mode_type;
    typedef enum logic [1:0] {boot_capture, boot_settle, boot_check, boot_run} mcs_boot_type;

    typedef struct packed {
        logic              lock_s1, lock_s2;
        logic              tgl_s1, tgl_s2, tgl_s3;
        logic              sel_s1, sel_s2, dim_s1, dim_s2, usb_s1, usb_s2;
        mcs_boot_type      boot;
        logic              cfg_ext;
        mcs_rate_type      cfg_rate;
        logic              fmt56, f96k, xcvr, eq_rec, frame96;
        logic              src_ext, lock, sync_ok;
        mcs_in_status_type status;
        mcs_rate_type      rate;
        logic [11:0]       period_cnt, ref_cnt;
        logic [31:0]       hold_cnt;
        mcs_op_mode_type   mode;
        logic              mode_save, boot_backup, fw_pending;
        logic [6:0]        chan_count;
    } mcs_core_type;

    typedef struct packed {
        logic rst_s1, rst_s2, tgl;
    } mcs_link_type;
endpackage : mcs_pkg

/* verilog/mcs_clock_ctrl.sv */
`include "mcs_defines.svh"

// Record word FIFO, single clock, registered flags
module mcs_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             srst_in,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    // Drain side
    output logic [WIDTH-1:0]      out_data_out,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("mcs_fifo: DEPTH must be a power of two, at least 2");
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("mcs_fifo: WIDTH must be positive");
    end

    typedef struct packed {
        logic [AW:0]   cnt;
        logic [AW-1:0] wr, rd;
        logic          in_ready, out_valid;
    } mcs_fifo_state_type;

    mcs_fifo_state_type q, next_q;
    logic [WIDTH-1:0]   mem [DEPTH];
    logic               push, pop;

    // Pointer and flag update; flags registered so in_ready and out_valid are flops
    always_comb begin
        next_q = q;
        push = in_valid_in && q.in_ready;
        pop = q.out_valid && out_ready_in;
        if (push) begin
            next_q.wr = q.wr + 1'b1;
        end
        if (pop) begin
            next_q.rd = q.rd + 1'b1;
        end
        next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
        next_q.in_ready = next_q.cnt != (AW+1)'(DEPTH);
        next_q.out_valid = next_q.cnt != '0;
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            q <= '{cnt: '0, wr: '0, rd: '0, in_ready: 1'b1, out_valid: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    // Storage carries no reset; only words behind valid are ever read
    always_ff @(posedge core_clk_in) begin
        if (push) begin
            mem[q.wr] <= in_data_in;
        end
    end

    assign in_ready_out  = q.in_ready;
    assign out_valid_out = q.out_valid;
    assign out_data_out  = mem[q.rd];
endmodule : mcs_fifo

// Clock source, input supervision, output format and operating mode
module mcs_clock_ctrl import mcs_pkg::*; #(
    parameter int unsigned HOLD_CYC   = `MCS_HOLD_CYC,
    parameter int          REC_WIDTH  = 24,
    parameter int          FIFO_DEPTH = 16
) (
    // Clocks and reset
    input  wire logic                 core_clk_in,
    input  wire logic                 srst_in,
    input  wire logic                 link_clk_in,
    // Recovered MADI link
    input  wire logic                 link_frame_in,
    input  wire logic                 link_lock_in,
    // Configuration
    input  wire logic                 clk_src_ext_in,
    input  wire mcs_rate_type         rate_cfg_in,
    input  wire logic                 madi_56ch_in,
    input  wire logic                 madi_96k_frame_in,
    input  wire logic                 madi_io_en_in,
    input  wire logic                 eq_record_in,
    // Panel, USB and boot
    input  wire logic                 select_button_in,
    input  wire logic                 attenuate_button_in,
    input  wire logic                 usb_present_in,
    input  wire mcs_op_mode_type      stored_mode_in,
    input  wire logic                 fw_update_fail_in,
    input  wire logic                 fw_fail_flag_in,
    // Record words in
    input  wire logic [REC_WIDTH-1:0] rec_dry_in,
    input  wire logic [REC_WIDTH-1:0] rec_eq_in,
    input  wire logic [REC_WIDTH-1:0] rec_out_eq_in,
    input  wire logic                 rec_loopback_in,
    input  wire logic                 rec_valid_in,
    output logic                      rec_ready_out,
    // Record words out
    output logic [REC_WIDTH-1:0]      rec_data_out,
    output logic                      rec_valid_out,
    input  wire logic                 rec_ready_in,
    // Status
    output logic                      cur_src_ext_out,
    output mcs_in_status_type         in_status_out,
    output mcs_rate_type              in_rate_out,
    output logic [6:0]                chan_count_out,
    output mcs_op_mode_type           meter_mode_out,
    output logic                      mode_save_out,
    output logic                      boot_backup_out,
    output logic                      fw_fail_pending_out,
    // MADI transmitter
    output logic                      madi_56ch_out,
    output logic                      madi_96k_frame_out,
    output logic                      madi_xcvr_pwr_out
);
    if (HOLD_CYC < 2) begin : g_bad_hold
        $error("mcs_clock_ctrl: HOLD_CYC must be at least 2");
    end

    // Coarse rate from frame period
    function automatic mcs_rate_type rate_of(input logic [11:0] p);
        if (p >= `MCS_P_NONE) begin
            return rate_none;
        end else if (p >= `MCS_P_32K) begin
            return rate_32k;
        end else if (p >= `MCS_P_44K1) begin
            return rate_44k1;
        end else if (p >= `MCS_P_48K) begin
            return rate_48k;
        end else if (p >= `MCS_P_64K) begin
            return rate_64k;
        end else if (p >= `MCS_P_88K2) begin
            return rate_88k2;
        end else if (p >= `MCS_P_96K) begin
            return rate_96k;
        end else if (p >= `MCS_P_128K) begin
            return rate_128k;
        end else if (p >= `MCS_P_176K4) begin
            return rate_176k4;
        end else if (p >= `MCS_P_192K) begin
            return rate_192k;
        end
        return rate_none;
    endfunction : rate_of

    // Nominal word period of a rate
    function automatic logic [11:0] nominal_of(input mcs_rate_type r);
        case (r)
            rate_32k:   return `MCS_N_32K;
            rate_44k1:  return `MCS_N_44K1;
            rate_64k:   return `MCS_N_64K;
            rate_88k2:  return `MCS_N_88K2;
            rate_96k:   return `MCS_N_96K;
            rate_128k:  return `MCS_N_128K;
            rate_176k4: return `MCS_N_176K4;
            rate_192k:  return `MCS_N_192K;
            default:    return `MCS_N_48K;
        endcase
    endfunction : nominal_of

    // Multiplex shift: 0 single, 1 double, 2 quad speed
    function automatic logic [1:0] speed_of(input mcs_rate_type r);
        case (r)
            rate_64k, rate_88k2, rate_96k:    return 2'h1;
            rate_128k, rate_176k4, rate_192k: return 2'h2;
            default:                          return 2'h0;
        endcase
    endfunction : speed_of

    mcs_core_type     q, next_q;
    mcs_link_type     lq, next_lq;
    logic             frame_edge;
    logic             phase_ok;
    logic             both_held;
    mcs_rate_type     act_rate;
    logic [11:0]      nom;
    logic [REC_WIDTH-1:0] rec_word;

    // Link side: one toggle per received frame, crossed as an event
    always_comb begin
        next_lq = lq;
        next_lq.rst_s1 = srst_in;
        next_lq.rst_s2 = lq.rst_s1;
        if (lq.rst_s2) begin
            next_lq.tgl = 1'b0;
        end else if (link_frame_in) begin
            next_lq.tgl = ~lq.tgl;
        end
    end

    always_ff @(posedge link_clk_in) begin
        lq <= next_lq;
    end

    // Core side combinational next state
    always_comb begin
        next_q = q;
        frame_edge = q.tgl_s2 ^ q.tgl_s3;
        both_held = q.sel_s2 && q.dim_s2;
        act_rate = q.src_ext ? q.rate : q.cfg_rate;
        nom = nominal_of(act_rate);
        phase_ok = (q.ref_cnt <= `MCS_SYNC_TOL) || (q.ref_cnt >= nom - 12'h001 - `MCS_SYNC_TOL);
        next_q.mode_save = 1'b0;

        // Pin synchronisers
        next_q.lock_s1 = link_lock_in;
        next_q.lock_s2 = q.lock_s1;
        next_q.tgl_s1 = lq.tgl;
        next_q.tgl_s2 = q.tgl_s1;
        next_q.tgl_s3 = q.tgl_s2;
        next_q.sel_s1 = select_button_in;
        next_q.sel_s2 = q.sel_s1;
        next_q.dim_s1 = attenuate_button_in;
        next_q.dim_s2 = q.dim_s1;
        next_q.usb_s1 = usb_present_in;
        next_q.usb_s2 = q.usb_s1;

        // Settings follow their inputs on the next edge; frame96 and chan_count follow one edge after that
        next_q.cfg_ext = clk_src_ext_in;
        next_q.cfg_rate = rate_cfg_in;
        next_q.fmt56 = madi_56ch_in;
        next_q.f96k = madi_96k_frame_in;
        next_q.xcvr = madi_io_en_in;
        next_q.eq_rec = eq_record_in;
        next_q.frame96 = q.f96k && (speed_of(act_rate) == 2'h1);
        next_q.chan_count = (q.fmt56 ? `MCS_CH_56 : `MCS_CH_64) >> speed_of(act_rate);

        // Frame period measure, saturating at full scale
        if (frame_edge) begin
            next_q.period_cnt = '0;
            next_q.rate = rate_of(12'(q.period_cnt + 12'h001));
        end else if (q.period_cnt != 12'hfff) begin
            next_q.period_cnt = q.period_cnt + 12'h001;
        end
        // Silent or powered-down input carries no rate
        if (!q.xcvr || q.period_cnt >= `MCS_NOFRAME_CYC) begin
            next_q.rate = rate_none;
        end

        // Lock needs the receiver flag, frames, a known rate and power
        next_q.lock = q.lock_s2 && q.xcvr && (q.period_cnt < `MCS_NOFRAME_CYC)
                      && (q.rate != rate_none);
        // Fall back to the crystal whenever lock drops
        next_q.src_ext = q.cfg_ext && next_q.lock;

        // Internal word reference; slaved to frames when the input is in use
        if (q.src_ext && frame_edge) begin
            next_q.ref_cnt = nom - 12'h001;
        end else if (q.ref_cnt == '0 || q.ref_cnt >= nom) begin
            next_q.ref_cnt = nom - 12'h001;
        end else begin
            next_q.ref_cnt = q.ref_cnt - 12'h001;
        end

        // Sync judged at each frame against the active reference
        if (!next_q.lock) begin
            next_q.sync_ok = 1'b0;
        end else if (frame_edge) begin
            next_q.sync_ok = phase_ok && (q.rate == q.cfg_rate);
        end
        if (!next_q.lock) begin
            next_q.status = in_no_lock;
        end else if (next_q.sync_ok) begin
            next_q.status = in_sync;
        end else begin
            next_q.status = in_lock;
        end

        // Firmware failure kept until the next cold boot
        if (fw_update_fail_in) begin
            next_q.fw_pending = 1'b1;
        end

        // Boot capture, then power-up and stand-alone mode toggles
        case (q.boot)
            boot_capture: begin
                next_q.mode = stored_mode_in;
                next_q.boot_backup = fw_fail_flag_in;
                next_q.boot = boot_settle;
            end
            boot_settle: begin
                next_q.boot = boot_check;
            end
            boot_check: begin
                // USB may be the very supply here, so it does not block
                if (both_held) begin
                    next_q.mode = q.mode == class_compliant_mode ?
                                  driver_normal_mode : class_compliant_mode;
                    next_q.mode_save = 1'b1;
                end
                next_q.boot = boot_run;
            end
            boot_run: begin
                if (both_held && !q.usb_s2) begin
                    if (q.hold_cnt >= 32'(HOLD_CYC - 1)) begin
                        next_q.hold_cnt = '0;
                        next_q.mode = q.mode == class_compliant_mode ?
                                      driver_normal_mode : class_compliant_mode;
                        next_q.mode_save = 1'b1;
                    end else begin
                        next_q.hold_cnt = q.hold_cnt + 32'h1;
                    end
                end else begin
                    next_q.hold_cnt = '0;
                end
            end
            default: begin
                next_q.boot = boot_capture;
            end
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            q <= `MCS_RST_CORE;
        end else begin
            q <= next_q;
        end
    end

    // Record source: dry input, or with EQ record on the EQ'd input, or EQ'd output channel under loopback
    always_comb begin
        if (!q.eq_rec) begin
            rec_word = rec_dry_in;
        end else if (rec_loopback_in) begin
            rec_word = rec_out_eq_in;
        end else begin
            rec_word = rec_eq_in;
        end
    end

    // Record words buffered; a stalled drain holds off the source
    mcs_fifo #(
        .WIDTH (REC_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_rec_fifo (
        .core_clk_in   (core_clk_in),
        .srst_in       (srst_in),
        .in_data_in    (rec_word),
        .in_valid_in   (rec_valid_in),
        .in_ready_out  (rec_ready_out),
        .out_data_out  (rec_data_out),
        .out_valid_out (rec_valid_out),
        .out_ready_in  (rec_ready_in)
    );

    // Status and transmitter outputs, all flops
    assign cur_src_ext_out     = q.src_ext;
    assign in_status_out       = q.status;
    assign in_rate_out         = q.rate;
    assign chan_count_out      = q.chan_count;
    assign meter_mode_out      = q.mode;
    assign mode_save_out       = q.mode_save;
    assign boot_backup_out     = q.boot_backup;
    assign fw_fail_pending_out = q.fw_pending;
    assign madi_56ch_out       = q.fmt56;
    assign madi_96k_frame_out  = q.frame96;
    assign madi_xcvr_pwr_out   = q.xcvr;

    // Checks in the core domain
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);

    no_lock_src_a: assert property (in_status_out == in_no_lock |-> !cur_src_ext_out)
        else $error("external source in use without lock");
    // Source follows on the very next edge; a later look races a lock loss
    ext_follow_a: assert property (
        q.cfg_ext && q.lock_s2 && q.xcvr && q.rate != rate_none
        && q.period_cnt < `MCS_NOFRAME_CYC |=> cur_src_ext_out)
        else $error("valid input not taken as clock source");
    silent_nolock_a: assert property (q.period_cnt >= `MCS_NOFRAME_CYC
        |=> in_status_out == in_no_lock)
        else $error("silent input not reported as no lock");
    rate_48k_a: assert property (frame_edge && q.xcvr
        && q.period_cnt >= 12'h2e4 && q.period_cnt <= 12'h35c |=> in_rate_out == rate_48k)
        else $error("48 kHz period not classified");
    // Rate and source pinned for the edge that forms the count
    chan_56_a: assert property (madi_56ch_in && rate_cfg_in == rate_48k
        ##1 !q.src_ext |=> chan_count_out == `MCS_CH_56)
        else $error("56 channel format not applied");
    chan_quad_a: assert property (!q.fmt56 && !q.src_ext && q.cfg_rate == rate_192k
        |=> chan_count_out == 7'h10)
        else $error("quad speed channel count wrong");
    frame96_a: assert property (madi_96k_frame_out |-> $past(q.f96k)
        && speed_of($past(act_rate)) == 2'h1)
        else $error("96K frame outside double speed");
    xcvr_off_a: assert property (!madi_io_en_in |=> !madi_xcvr_pwr_out
        ##1 in_status_out == in_no_lock [*2])
        else $error("powered-down transceiver still locked");
    usb_block_a: assert property (q.boot == boot_run && q.usb_s2 |=> !mode_save_out)
        else $error("mode changed with USB present");
    sync_cond_a: assert property (in_status_out == in_sync |-> q.lock
        && q.rate == $past(q.cfg_rate, 2))
        else $error("sync without lock or matching rate");
    fw_keep_a: assert property (fw_update_fail_in |=> fw_fail_pending_out [*8])
        else $error("firmware failure not kept");

    sync_seen_c: cover property (in_status_out == in_sync);
    ext_src_c: cover property ($rose(cur_src_ext_out));
    mode_toggle_c: cover property (mode_save_out && q.boot == boot_run);
    fifo_full_c: cover property (rec_valid_in && !rec_ready_out);
endmodule : mcs_clock_ctrl

/* testbench/mcs_madi_partner.sv */
module mcs_madi_partner (
    // Far-side control
    input  wire logic        on_in,
    input  wire logic [11:0] period_in,
    // Link pins
    output logic             link_clk_out,
    output logic             link_frame_out,
    output logic             link_lock_out
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    // Recovered clock exists only while a signal is sent
    initial begin
        link_clk_out = 1'b0;
        forever #32 link_clk_out = on_in ? ~link_clk_out : 1'b0;
    end
    // One link cycle of frame pulse per period
    always @(negedge link_clk_out) begin
        cnt = (cnt + 1 >= period_in) ? 0 : cnt + 1;
        link_frame_out <= (cnt == 0);
    end
    assign link_lock_out = on_in;
endmodule : mcs_madi_partner

/* testbench/testbench.sv */
module testbench import mcs_pkg::*; ;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk_in, srst_in, link_clk_in, link_frame_in, link_lock_in, clk_src_ext_in;
    logic madi_56ch_in, madi_96k_frame_in, madi_io_en_in, eq_record_in, select_button_in;
    logic attenuate_button_in, usb_present_in, fw_update_fail_in, fw_fail_flag_in, link_on;
    logic rec_loopback_in, rec_valid_in, rec_ready_in, rec_ready_out, rec_valid_out;
    logic cur_src_ext_out, mode_save_out, boot_backup_out, fw_fail_pending_out;
    logic madi_56ch_out, madi_96k_frame_out, madi_xcvr_pwr_out;
    logic [23:0] rec_dry_in, rec_eq_in, rec_out_eq_in, rec_data_out;
    logic [11:0] link_period;
    logic [6:0] chan_count_out;
    mcs_rate_type rate_cfg_in, in_rate_out;
    mcs_op_mode_type stored_mode_in, meter_mode_out;
    mcs_in_status_type in_status_out;
    int errors = 0;
    int tests_run = 0;
    int saves = 0;
    logic [11:0] per[3] = '{12'h1e8, 12'h162, 12'h145};
    mcs_rate_type rts[3] = '{rate_32k, rate_44k1, rate_48k};
    // Short hold count keeps the two-second press quick
    mcs_clock_ctrl #(.HOLD_CYC(50)) mcs_clock_ctrl_inst (.core_clk_in, .srst_in, .link_clk_in,
        .link_frame_in, .link_lock_in, .clk_src_ext_in, .rate_cfg_in, .madi_56ch_in,
        .madi_96k_frame_in, .madi_io_en_in, .eq_record_in, .select_button_in,
        .attenuate_button_in, .usb_present_in, .stored_mode_in, .fw_update_fail_in,
        .fw_fail_flag_in, .rec_dry_in, .rec_eq_in, .rec_out_eq_in, .rec_loopback_in,
        .rec_valid_in, .rec_ready_out, .rec_data_out, .rec_valid_out, .rec_ready_in,
        .cur_src_ext_out, .in_status_out, .in_rate_out, .chan_count_out, .meter_mode_out,
        .mode_save_out, .boot_backup_out, .fw_fail_pending_out, .madi_56ch_out,
        .madi_96k_frame_out, .madi_xcvr_pwr_out);
    mcs_madi_partner mcs_madi_partner_inst (.on_in(link_on), .period_in(link_period),
        .link_clk_out(link_clk_in), .link_frame_out(link_frame_in),
        .link_lock_out(link_lock_in));
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic cyc(int n);
        repeat (n) @(negedge core_clk_in);
    endtask : cyc
    // Hold the word until ready is seen at an edge
    task automatic push(int i);
        rec_dry_in = 24'(i);
        rec_eq_in = 24'(i + 32'h100);
        rec_out_eq_in = 24'(i + 32'h200);
        rec_loopback_in = i[0];
        rec_valid_in = 1'b1;
        // Ready is a flop: its falling-edge value is what the next rising edge takes
        while (rec_ready_out !== 1'b1) cyc(1);
        cyc(1);
    endtask : push
    task automatic complete_run();
        $display("comparisons %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end
    // Mode save pulses counted mid-cycle, where each one stands
    always @(negedge core_clk_in) begin
        if (mode_save_out === 1'b1) saves++;
    end
    // Watchdog, well above the expected 10k cycles
    initial begin
        #2000000;
        errors++;
        complete_run();
    end
    // Main sequence, inputs change at falling edges
    initial begin
        {clk_src_ext_in, madi_96k_frame_in, select_button_in, attenuate_button_in,
         usb_present_in, fw_update_fail_in, fw_fail_flag_in, rec_valid_in,
         rec_ready_in, rec_loopback_in, rec_dry_in, rec_eq_in, rec_out_eq_in} = '0;
        {srst_in, link_on, madi_56ch_in, madi_io_en_in, eq_record_in} = '1;
        link_period = per[0];
        rate_cfg_in = rate_48k;
        stored_mode_in = class_compliant_mode;
        cyc(6);
        srst_in = 1'b0;
        cyc(3);
        check("meter", meter_mode_out, class_compliant_mode);
        check("fmt56", madi_56ch_out, 1);
        check("xcvr", madi_xcvr_pwr_out, 1);
        check("chan56", chan_count_out, 7'h38);
        rate_cfg_in = rate_96k;
        madi_96k_frame_in = 1'b1;
        cyc(3);
        check("f96", madi_96k_frame_out, 1);
        check("chan_ds", chan_count_out, 7'h1c);
        rate_cfg_in = rate_192k;
        madi_56ch_in = 1'b0;
        cyc(3);
        check("f96_qs", madi_96k_frame_out, 0);
        check("chan_qs", chan_count_out, 7'h10);
        rate_cfg_in = rate_48k;
        // Source stays internal until the optical input is chosen
        for (int i = 0; i < 3; i++) begin
            link_period = per[i];
            repeat (6000) if (in_rate_out !== rts[i]) cyc(1);
            cyc(4);
            check("rate", in_rate_out, rts[i]);
            check("src", cur_src_ext_out, i > 0);
            check("lock", in_status_out == in_no_lock, 0);
            clk_src_ext_in = 1'b1;
        end
        repeat (4000) if (in_status_out !== in_sync) cyc(1);
        check("sync", in_status_out, in_sync);
        // Transceiver off drops lock at once, frames or not
        madi_io_en_in = 1'b0;
        cyc(3);
        check("xcvr_off", madi_xcvr_pwr_out, 0);
        check("off_lock", in_status_out, in_no_lock);
        check("off_rate", in_rate_out, rate_none);
        check("off_src", cur_src_ext_out, 0);
        madi_io_en_in = 1'b1;
        link_on = 1'b0;
        cyc(4200);
        check("lost", in_status_out, in_no_lock);
        check("src_lost", cur_src_ext_out, 0);
        check("rate_lost", in_rate_out, rate_none);
        // Fill against a stalled reader, then drain
        for (int i = 0; i < 16; i++) push(i);
        rec_valid_in = 1'b0;
        cyc(1);
        check("full", rec_ready_out, 0);
        rec_ready_in = 1'b1;
        for (int i = 0; i < 16; i++) begin
            while (rec_valid_out !== 1'b1) cyc(1);
            check("rec", rec_data_out, i[0] ? 24'h200 + i : 24'h100 + i);
            cyc(1);
        end
        check("empty", rec_valid_out, 0);
        // Record option off: the dry word wins over loopback
        eq_record_in = 1'b0;
        cyc(1);
        push(5);
        rec_valid_in = 1'b0;
        check("dry_valid", rec_valid_out, 1);
        check("dry", rec_data_out, 24'h5);
        {select_button_in, attenuate_button_in} = 2'h3;
        cyc(75);
        check("hold1", meter_mode_out, driver_normal_mode);
        cyc(50);
        check("hold2", meter_mode_out, class_compliant_mode);
        check("saves", saves, 2);
        usb_present_in = 1'b1;
        cyc(75);
        check("usb", meter_mode_out, class_compliant_mode);
        check("usb_save", saves, 2);
        fw_update_fail_in = 1'b1;
        cyc(1);
        {fw_update_fail_in, fw_fail_flag_in, link_on} = 3'h3;
        cyc(1);
        check("fw", fw_fail_pending_out, 1);
        srst_in = 1'b1;
        cyc(6);
        srst_in = 1'b0;
        cyc(8);
        check("backup", boot_backup_out, 1);
        check("boot", meter_mode_out, driver_normal_mode);
        check("boot_save", saves, 3);
        complete_run();
    end
endmodule : testbench
